// file: hdl/varu_map.svh
// register offsets, field positions and field codes of the relocation unit
`ifndef VARU_MAP_SVH
`define VARU_MAP_SVH
`define VARU_OFF_PAGES 9'h000
`define VARU_PAGES_TOP 9'h07C
`define VARU_OFF_CTRL 9'h100
`define VARU_OFF_STATUS 9'h104
`define VARU_OFF_MASK 9'h108
`define VARU_OFF_ABTINFO 9'h10C
`define VARU_CTRL_ENABLE 0
`define VARU_EVT_ABORT 0
`define VARU_EVT_MODE 1
`define VARU_EVT_WIDTH 2
`define VARU_BASE_MASK 16'h0FFF
`define VARU_KEY_HI 2
`define VARU_KEY_LO 1
`define VARU_KEY_RDONLY 2'h1
`define VARU_KEY_RDWR 2'h3
`define VARU_LEN_HI 14
`define VARU_LEN_LO 8
`define VARU_MODE_KERNEL 2'h0
`define VARU_MODE_USER 2'h3
`define VARU_IO_PAGE 3'h7
`define VARU_BLOCK_SHIFT 6
`endif

// file: hdl/varu_pkg.sv
// types shared by the relocation unit modules
package varu_pkg;
  typedef enum logic [2:0] {ABT_NONE, ABT_MODE, ABT_NONRES, ABT_RDONLY, ABT_LENGTH} varu_abort_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] mode;
    logic [15:0] virtual_addr;
  } varu_cpu_req_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic [17:0] physical_addr;
  } varu_bus_req_type;
  typedef struct packed {
    logic abort;
    varu_abort_type reason;
    logic [17:0] physical_addr;
  } varu_xlate_type;
endpackage

// file: hdl/varu_page_regs.sv
// two sets of eight base/descriptor register pairs
`timescale 1ns/100ps
`include "varu_map.svh"
module varu_page_regs import varu_pkg::*; (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic wr_en, // write strobe
  input wire logic [4:0] wr_idx, // {user, desc, page}
  input wire logic [15:0] wr_data, // write data
  input wire logic [1:0] wr_lanes, // byte enables
  input wire logic [4:0] rd_idx, // software read index
  output logic [15:0] rd_data, // software read data
  input wire logic set_user, // select user set
  input wire logic [2:0] page, // virtual page number
  output logic [15:0] page_base, // selected page base reg
  output logic [15:0] page_desc // selected page descriptor reg
);
  logic [15:0] regs_q [0:31];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 32; i++) begin
        regs_q[i] <= 16'h0000;
      end
    end else if (wr_en) begin
      for (int b = 0; b < 2; b++) begin
        if (wr_lanes[b]) begin
          regs_q[wr_idx][b*8 +: 8] <= wr_data[b*8 +: 8];
        end
      end
      if (!wr_idx[3]) begin
        // upper four base bits unused, kept zero
        regs_q[wr_idx][15:12] <= 4'h0;
      end
    end
  end

  assign rd_data = regs_q[rd_idx];
  assign page_base = regs_q[{set_user, 1'b0, page}];
  assign page_desc = regs_q[{set_user, 1'b1, page}];
endmodule

// file: hdl/varu_xlate.sv
// combinational virtual to physical translation and access check
`timescale 1ns/100ps
`include "varu_map.svh"
module varu_xlate import varu_pkg::*; (
  input wire varu_cpu_req_type req, // request from core
  input wire logic enable, // translation active
  input wire logic [15:0] page_base, // selected base reg
  input wire logic [15:0] page_desc, // selected descriptor reg
  output varu_xlate_type result // abort and address
);
  logic [1:0] key;
  logic [6:0] last_block;
  logic [17:0] base_bytes;

  assign key = page_desc[`VARU_KEY_HI:`VARU_KEY_LO];
  assign last_block = page_desc[`VARU_LEN_HI:`VARU_LEN_LO];
  assign base_bytes = {page_base[11:0], 6'h00};

  always_comb begin
    result.abort = 1'b0;
    result.reason = ABT_NONE;
    if (!enable) begin
      if (req.virtual_addr[15:13] == `VARU_IO_PAGE) begin
        result.physical_addr = {2'h3, req.virtual_addr};
      end else begin
        result.physical_addr = {2'h0, req.virtual_addr};
      end
    end else begin
      // offset 13 bits plus block-aligned base; overlap is never checked
      result.physical_addr = base_bytes + {5'h00, req.virtual_addr[12:0]};
      if (req.mode != `VARU_MODE_KERNEL && req.mode != `VARU_MODE_USER) begin
        result.abort = 1'b1;
        result.reason = ABT_MODE;
      end else if (key != `VARU_KEY_RDONLY && key != `VARU_KEY_RDWR) begin
        result.abort = 1'b1;
        result.reason = ABT_NONRES;
      end else if (key == `VARU_KEY_RDONLY && req.write) begin
        result.abort = 1'b1;
        result.reason = ABT_RDONLY;
      end else if (req.virtual_addr[12:6] > last_block) begin
        result.abort = 1'b1;
        result.reason = ABT_LENGTH;
      end
    end
  end
endmodule

// file: hdl/varu_top.sv
// relocation and protection unit: core port, bus port, wishbone registers
// Operation
// - virtual addresses are 16-bit byte addresses and physical ones are 18 bits.
// - untranslated addresses in the top 4K words get both upper bits set.
// - untranslated addresses below the top 4K words get both upper bits clear.
// - two sets of eight pairs each hold a 16-bit base and a 16-bit descriptor.
// - the processor mode picks the kernel or the user set for each access.
// - the virtual space is eight 4K-word pages each with its own pair.
// - with translation on, the address always comes from the page pair.
// - a page spans 1 to 128 blocks of 32 words.
// - a page base is counted in 32-word blocks.
// - references past the page length are refused.
// - pages may map to the same or overlapping memory with no check.
// - each page is no access, read only, or read and write.
// - the base holds a 12-bit field and its upper four bits are unused.
// - key 0 aborts all, key 2 aborts writes, key 6 allows all, aborts never complete.
// - mode 00 selects kernel, and with translation on illegal mode codes abort every reference.
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "varu_map.svh"
module varu_top import varu_pkg::*; (
  input wire logic clk_sys, // 250 MHz system clock
  input wire logic nrst, // async reset, active low
  input wire varu_cpu_req_type cpu_req, // one-cycle access request
  output varu_bus_req_type bus_req, // translated bus cycle
  output logic cpu_abort, // access aborted pulse
  output varu_abort_type abort_reason, // why last access aborted
  output logic irq, // level interrupt
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [8:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone ack
  output logic wb_err_o // wishbone error, unmapped
);
  logic ctrl_enable_q;
  logic [`VARU_EVT_WIDTH-1:0] status_q;
  logic [`VARU_EVT_WIDTH-1:0] mask_q;
  logic [19:0] abt_info_q;
  logic [15:0] page_rd;
  logic [15:0] page_base;
  logic [15:0] page_desc;
  logic set_user;
  logic bus_take;
  logic bus_wr;
  logic in_pages;
  varu_xlate_type xl;
  logic [`VARU_EVT_WIDTH-1:0] evt;

  function automatic logic is_pages(input logic [8:0] a);
    return a <= `VARU_PAGES_TOP;
  endfunction

  function automatic logic is_known(input logic [8:0] a);
    return is_pages(a) || a == `VARU_OFF_CTRL || a == `VARU_OFF_STATUS ||
           a == `VARU_OFF_MASK || a == `VARU_OFF_ABTINFO;
  endfunction

  assign bus_take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign bus_wr = bus_take && wb_we_i && is_known(wb_adr_i);
  assign in_pages = is_pages(wb_adr_i);

  // user set for mode 11, kernel otherwise; illegal modes abort anyway
  assign set_user = cpu_req.mode == `VARU_MODE_USER;

  varu_page_regs u_regs (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .wr_en(bus_wr && in_pages),
    .wr_idx(wb_adr_i[6:2]),
    .wr_data(wb_dat_i[15:0]),
    .wr_lanes(wb_sel_i[1:0]),
    .rd_idx(wb_adr_i[6:2]),
    .rd_data(page_rd),
    .set_user(set_user),
    .page(cpu_req.virtual_addr[15:13]),
    .page_base(page_base),
    .page_desc(page_desc)
  );

  varu_xlate u_xlate (
    .req(cpu_req),
    .enable(ctrl_enable_q),
    .page_base(page_base),
    .page_desc(page_desc),
    .result(xl)
  );

  // core side: result one cycle after the request
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bus_req <= '0;
      cpu_abort <= 1'b0;
    end else begin
      // aborted references never reach the bus
      bus_req.valid <= cpu_req.valid && !xl.abort;
      bus_req.write <= cpu_req.write;
      bus_req.physical_addr <= xl.physical_addr;
      cpu_abort <= cpu_req.valid && xl.abort;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      abort_reason <= ABT_NONE;
      abt_info_q <= 20'h00000;
    end else if (cpu_req.valid && xl.abort) begin
      abort_reason <= xl.reason;
      abt_info_q <= {cpu_req.write, xl.reason, cpu_req.virtual_addr};
    end
  end

  assign evt[`VARU_EVT_ABORT] = cpu_req.valid && xl.abort;
  assign evt[`VARU_EVT_MODE] = cpu_req.valid && xl.abort && xl.reason == ABT_MODE;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_enable_q <= 1'b0;
      mask_q <= '0;
    end else if (bus_wr && wb_sel_i[0]) begin
      if (wb_adr_i == `VARU_OFF_CTRL) begin
        ctrl_enable_q <= wb_dat_i[`VARU_CTRL_ENABLE];
      end
      if (wb_adr_i == `VARU_OFF_MASK) begin
        mask_q <= wb_dat_i[`VARU_EVT_WIDTH-1:0];
      end
    end
  end

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status_q <= '0;
    end else if (bus_wr && wb_sel_i[0] && wb_adr_i == `VARU_OFF_STATUS) begin
      status_q <= (status_q & ~wb_dat_i[`VARU_EVT_WIDTH-1:0]) | evt;
    end else begin
      status_q <= status_q | evt;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_take && is_known(wb_adr_i);
      wb_err_o <= bus_take && !is_known(wb_adr_i);
      wb_dat_o <= 32'h00000000;
      if (bus_take && !wb_we_i) begin
        if (in_pages) begin
          wb_dat_o <= {16'h0000, page_rd};
        end else if (wb_adr_i == `VARU_OFF_CTRL) begin
          wb_dat_o <= {31'h00000000, ctrl_enable_q};
        end else if (wb_adr_i == `VARU_OFF_STATUS) begin
          wb_dat_o <= {30'h00000000, status_q};
        end else if (wb_adr_i == `VARU_OFF_MASK) begin
          wb_dat_o <= {30'h00000000, mask_q};
        end else if (wb_adr_i == `VARU_OFF_ABTINFO) begin
          wb_dat_o <= {12'h000, abt_info_q};
        end
      end
    end
  end
endmodule

// file: bench/varu_checker.sv
// assertions on the relocation unit ports
`timescale 1ns/100ps
module varu_checker import varu_pkg::*; (
  input wire logic clk_sys, // clock
  input wire logic nrst, // reset
  input wire varu_cpu_req_type cpu_req, // core
  input wire varu_bus_req_type bus_req, // bus
  input wire logic cpu_abort, // abort
  input wire varu_abort_type abort_reason, // reason
  input wire logic wb_cyc_i, // cyc
  input wire logic wb_stb_i, // stb
  input wire logic wb_we_i, // we
  input wire logic [8:0] wb_adr_i, // adr
  input wire logic [3:0] wb_sel_i, // sel
  input wire logic [31:0] wb_dat_i, // data
  input wire logic wb_ack_o, // ack
  input wire logic wb_err_o // err
);
  logic en_q;
  logic take;
  logic [15:0] va;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign va = cpu_req.virtual_addr;
  // enable bit is internal, so shadow it from the register writes
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) en_q <= 1'b0;
    else if (take && wb_we_i && wb_adr_i == 9'h100 && wb_sel_i[0]) en_q <= wb_dat_i[0];
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence req_s; cpu_req.valid; endsequence
  sequence ans_s; bus_req.valid ^ cpu_abort; endsequence
  sequence pass_s; req_s ##1 bus_req.valid; endsequence
  one_answer_a: assert property (req_s |=> ans_s) else $error("no single answer");
  quiet_bus_a: assert property (!cpu_req.valid |=> !bus_req.valid && !cpu_abort)
    else $error("stray answer");
  io_page_a: assert property (!en_q && cpu_req.valid && va[15:13] == 3'h7
    |=> bus_req.physical_addr == {2'h3, $past(va)}) else $error("io page address");
  low_mem_a: assert property (!en_q && cpu_req.valid && va[15:13] != 3'h7
    |=> bus_req.physical_addr == {2'h0, $past(va)}) else $error("memory address");
  off_pass_a: assert property (!en_q && cpu_req.valid
    |=> bus_req.valid && bus_req.write == $past(cpu_req.write)) else $error("untranslated access");
  mode_abort_a: assert property (en_q && cpu_req.valid && cpu_req.mode inside {2'h1, 2'h2}
    |=> cpu_abort && abort_reason == ABT_MODE) else $error("mode not aborted");
  rdonly_a: assert property (cpu_abort && abort_reason == ABT_RDONLY |-> $past(cpu_req.write))
    else $error("read refused");
  wb_answer_a: assert property (take |=> wb_ack_o ^ wb_err_o) else $error("bus not answered");
  pass_write_a: assert property (pass_s |-> bus_req.write == $past(cpu_req.write))
    else $error("bus direction");
  // base is whole blocks, so the low six byte bits pass unchanged
  block_align_a: assert property (en_q && cpu_req.valid ##1 bus_req.valid
    |-> bus_req.physical_addr[5:0] == $past(va[5:0])) else $error("block offset");
endmodule
bind varu_top varu_checker chk (.clk_sys, .nrst, .cpu_req, .bus_req, .cpu_abort, .abort_reason, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_err_o);

// file: bench/varu_mem_model.sv
// bus side memory that counts the stores it accepts
`timescale 1ns/100ps
module varu_mem_model import varu_pkg::*; (
  input wire logic clk_sys, // clock
  input wire logic nrst, // reset
  input wire varu_bus_req_type bus_req, // bus cycle
  output logic [15:0] write_count // stores taken
);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) write_count <= 16'h0000;
    else if (bus_req.valid && bus_req.write) write_count <= write_count + 16'h0001;
  end
endmodule

// file: bench/test_varu_top.sv
// self-checking bench for the relocation unit
`timescale 1ns/100ps
module test_varu_top;
  import varu_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  varu_cpu_req_type cpu_req = '0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [8:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0;
  varu_bus_req_type bus_req;
  varu_abort_type abort_reason;
  logic cpu_abort, irq, wb_ack_o, wb_err_o, wb_err;
  logic [31:0] wb_dat_o, rd;
  logic [15:0] write_count, va, wc;
  logic [11:0] bk;
  int err_total = 0;
  int samples_checked = 0;
  varu_xlate_type exp_q[$];
  always #2 clk_sys = ~clk_sys;
  varu_top dut (.clk_sys, .nrst, .cpu_req, .bus_req, .cpu_abort, .abort_reason, .irq, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o);
  varu_mem_model mem (.clk_sys, .nrst, .bus_req, .write_count);
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) err_total++;
    if (got !== exp) $display("BAD %0t got %h exp %h", $time, got, exp);
  endtask
  task automatic wb(input logic we, input logic [8:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, a, 4'hF, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (!wb_ack_o && !wb_err_o && n < 9);
    if (!wb_ack_o && !wb_err_o) begin
      err_total++;
      end_of_test();
    end else begin
      rd = wb_dat_o;
      wb_err = wb_err_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
    end
  endtask
  task automatic acc(input logic [1:0] m, input logic w, input logic [15:0] v, input varu_xlate_type e);
    @(posedge clk_sys);
    cpu_req <= {1'b1, w, m, v};
    exp_q.push_back(e);
  endtask
  task automatic idle();
    @(posedge clk_sys);
    cpu_req.valid <= 1'b0;
  endtask
  function automatic varu_xlate_type ok(input logic [17:0] p);
    return '{1'b0, ABT_NONE, p};
  endfunction
  function automatic varu_xlate_type ab(input varu_abort_type r);
    return '{1'b1, r, 18'h00000};
  endfunction
  function automatic logic [17:0] rel(input logic [15:0] v);
    return {bk, 6'h00} + {5'h00, v[12:0]};
  endfunction
  // outputs are registered, so the falling edge sees them settled
  always @(negedge clk_sys) begin
    if (bus_req.valid === 1'b1 || cpu_abort === 1'b1)
      cmp_w(32'({cpu_abort, cpu_abort ? abort_reason : ABT_NONE, cpu_abort ? 18'h00000 : bus_req.physical_addr}),
        32'(exp_q.pop_front()));
  end
  initial begin
    rd = $urandom(63588);
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    // translation off: any mode passes, nothing aborts
    for (int i = 0; i < 24; i++) begin
      va = 16'($urandom());
      acc(2'($urandom()), 1'($urandom()), va, ok({va[15:13] == 3'h7 ? 2'h3 : 2'h0, va}));
    end
    idle();
    bk = 12'($urandom());
    wb(1'b1, 9'h004, {20'h00000, bk});
    wb(1'b1, 9'h044, {20'h00000, bk});
    wb(1'b1, 9'h024, 32'h00000306);
    wb(1'b1, 9'h064, 32'h00007F02);
    wb(1'b1, 9'h028, 32'h00000004);
    wb(1'b1, 9'h100, 32'h00000001);
    wc = write_count;
    va = 16'h2000 | 16'($urandom_range(255));
    acc(2'h0, 1'b1, va, ok(rel(va)));
    acc(2'h3, 1'b0, va, ok(rel(va)));
    acc(2'h3, 1'b1, va, ab(ABT_RDONLY));
    acc(2'h0, 1'b0, 16'h20FF, ok(rel(16'h20FF)));
    acc(2'h0, 1'b0, 16'h2100, ab(ABT_LENGTH));
    acc(2'h1, 1'b0, va, ab(ABT_MODE));
    acc(2'h2, 1'b1, va, ab(ABT_MODE));
    acc(2'h0, 1'b0, 16'h4000, ab(ABT_NONRES));
    acc(2'h3, 1'b1, 16'hE000, ab(ABT_NONRES));
    idle();
    repeat (2) @(posedge clk_sys);
    cmp_w(32'(write_count - wc), 32'h00000001);
    // last abort: user store to page 7, not resident
    wb(1'b0, 9'h10C, 32'h00000000);
    cmp_w(rd, 32'h000AE000);
    wb(1'b0, 9'h104, 32'h00000000);
    cmp_w(rd, 32'h00000003);
    wb(1'b0, 9'h100, 32'h00000000);
    cmp_w(rd, 32'h00000001);
    wb(1'b1, 9'h00C, 32'h0000FFFF);
    wb(1'b0, 9'h00C, 32'h00000000);
    cmp_w(rd, 32'h00000FFF);
    wb(1'b0, 9'h110, 32'h00000000);
    cmp_w({wb_err, rd[30:0]}, 32'h80000000);
    cmp_w(32'(irq), 32'h00000000);
    wb(1'b1, 9'h108, 32'h00000001);
    repeat (2) @(posedge clk_sys);
    cmp_w(32'(irq), 32'h00000001);
    wb(1'b1, 9'h104, 32'h00000003);
    repeat (2) @(posedge clk_sys);
    cmp_w(32'(irq), 32'h00000000);
    // only the mode bit unmasked: a plain abort must not raise the line
    wb(1'b1, 9'h108, 32'h00000002);
    acc(2'h0, 1'b0, 16'h4000, ab(ABT_NONRES));
    idle();
    repeat (2) @(posedge clk_sys);
    cmp_w(32'(irq), 32'h00000000);
    wb(1'b0, 9'h104, 32'h00000000);
    cmp_w(rd, 32'h00000001);
    acc(2'h2, 1'b0, va, ab(ABT_MODE));
    idle();
    repeat (2) @(posedge clk_sys);
    cmp_w(32'(irq), 32'h00000001);
    cmp_w(exp_q.size(), 32'h00000000);
    end_of_test();
  end
endmodule
